// ### hw/scan_ctrl_pkg.sv
/*
  Constants, register map and carrier types for the run/stop and scan
  sequencing controller. Assumes a 250 MHz single clock and an APB master
  with 32-bit data.
*/
// Operation
// (R01) Run/stop input low holds the application stopped, whatever the terminal says.
// (R02) Rising edge on the run/stop input starts the application running.
// (R03) Run/stop input high: terminal run and stop commands act freely.
// (R04) Stop from the physical input outranks run from terminal or network.
// (R05) Input fault stops; fault clearing with input high resumes running.
// (R06) Cold start runs only if input high and fault-free.
// (R07) Warm restart runs only if input high, fault-free, no prior stop command.
// (R08) Warm restart: low or faulty stops; high-but-stopped before break stays stopped.
// (R09) Cyclic mode: scans back to back, internal, inputs, program, outputs.
// (R10) Stopped: only internal processing and input read; outputs take fallback.
// (R11) Force fallback drives constant 0 or 1, output image untouched.
// (R12) Hold fallback keeps each output at its last driven value.
// (R13) Periodic mode: period 1 to 255 ms from the period setting word.
// (R14) Down-counter loaded with period at scan start; zero launches next scan.
// (R15) Early-finishing periodic scan idles in background work until period ends.
// (R16) Overlong periodic scan sets period overrun flag, completes, restarts after outputs.
// (R17) Scan beyond watchdog limit sets flag, faults, stops at once, flashes lamps.
// (R18) Configuring party programs watchdog longer than the scan period.
// (R19) Configuring party keeps about 50 ms margin below the watchdog limit.
// (R20) Main task lowest, fast task medium and periodic, event tasks highest.
// (R21) Higher-priority task preempts lower one, which resumes after it completes.
// (R22) Up to 32 or 64 event tasks; top event task outranks the rest.
// (R23) Watchdog timer restarts at the start of every scan.
`default_nettype none
package scan_ctrl_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_PERIOD   = 8'h08;
  localparam logic [7:0] OFS_WDOG     = 8'h0C;
  localparam logic [7:0] OFS_FALLBACK = 8'h10;
  localparam logic [7:0] OFS_FAST     = 8'h14;
  localparam logic [7:0] OFS_TASK     = 8'h18;

  // control bits (write pulses)
  localparam int CTRL_RUN      = 0;
  localparam int CTRL_STOP     = 1;
  localparam int CTRL_CLRFAULT = 2;

  // status bits
  localparam int ST_RUNNING  = 0;
  localparam int ST_FAULTY   = 1;
  localparam int ST_WDOG     = 2;
  localparam int ST_POVR     = 3;
  localparam int ST_PIN      = 4;
  localparam int ST_PINFAULT = 5;

  // fallback codes, two bits per output group
  localparam logic [1:0] FB_HOLD   = 2'h0;
  localparam logic [1:0] FB_FORCE0 = 2'h2;
  localparam logic [1:0] FB_FORCE1 = 2'h3;

  // reset values
  localparam logic [7:0]  PERIOD_RST = 8'h00;
  localparam logic [9:0]  WDOG_RST   = 10'h0FA;
  localparam logic [7:0]  FAST_RST   = 8'h00;

  // timing
  localparam int CLK_NS        = 4;
  localparam int MS_NS         = 1000000;
  localparam int MS_CYCLES     = MS_NS / CLK_NS;
  localparam int FLASH_HALF_MS = 250;
  localparam int START_WAIT    = 3;

  typedef enum logic [4:0] {
    PH_IDLE = 5'b00001,
    PH_IP   = 5'b00010,
    PH_IN   = 5'b00100,
    PH_PROG = 5'b01000,
    PH_OUT  = 5'b10000
  } scanPhase_t;

  typedef struct packed {
    logic       mainTask;
    logic       fastTask;
    logic       eventTask;
    logic [5:0] eventNum;
  } taskGrant_t;

endpackage
`default_nettype wire

// ### hw/scan_run_ctrl.sv
/*
  Run/stop state, restart decision, scan phase sequencer, period and
  watchdog timing, output fallback and task arbitration, with an APB
  register file. Assumes phase and task done strobes come from logic on
  clk; run/stop pin, pin fault and restart straps come from outside.
*/
`default_nettype none
module scan_run_ctrl
  import scan_ctrl_pkg::*;
#(
  parameter int MS_CNT  = MS_CYCLES,
  parameter int GROUPS  = 4,
  parameter int NEV     = 32
) (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  resetn,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // run/stop pin and restart context (asynchronous)
  input  wire logic                  runPin,
  input  wire logic                  runPinFault,
  input  wire logic                  warmStart,
  input  wire logic                  keptStopped,
  output logic                       keepStopped,
  // scan phases
  output scanPhase_t                 phase,
  input  wire logic                  phaseDone,
  // outputs and their image
  input  wire logic [GROUPS*8-1:0]   outImage,
  output logic      [GROUPS*8-1:0]   physOut,
  // tasks
  input  wire logic [NEV-1:0]        eventReq,
  input  wire logic                  taskDone,
  output taskGrant_t                 grant,
  // lamps and state
  output logic                       running,
  output logic                       runLamp,
  output logic                       errLamp
);

  localparam int NO = GROUPS * 8;

  // synchronisers for asynchronous inputs
  logic [3:0] syncA_ff;
  logic [3:0] syncB_ff;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      syncA_ff <= 4'h0;
      syncB_ff <= 4'h0;
    end else begin
      syncA_ff <= {keptStopped, warmStart, runPinFault, runPin};
      syncB_ff <= syncA_ff;
    end
  end
  logic pinHigh, pinFault, warmS, keptStopS;
  assign pinHigh   = syncB_ff[0];
  assign pinFault  = syncB_ff[1];
  assign warmS     = syncB_ff[2];
  assign keptStopS = syncB_ff[3];

  // millisecond tick
  logic [$clog2(MS_CNT)-1:0] msDiv_ff;
  logic                      msTick_ff;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      msDiv_ff  <= '0;
      msTick_ff <= 1'b0;
    end else if (msDiv_ff == ($clog2(MS_CNT))'(MS_CNT - 1)) begin
      msDiv_ff  <= '0;
      msTick_ff <= 1'b1;
    end else begin
      msDiv_ff  <= msDiv_ff + 1'b1;
      msTick_ff <= 1'b0;
    end
  end

  // registers
  logic [7:0]          period_ff;
  logic [9:0]          wdLimit_ff;
  logic [7:0]          fastPeriod_ff;
  logic [2*GROUPS-1:0] fallback_ff;
  logic                wdFlag_ff;
  logic                povrFlag_ff;
  logic                faulty_ff;
  logic                running_ff;

  logic apbWr, apbRd;
  assign apbWr = psel & penable & pready & pwrite;
  assign apbRd = psel & ~penable;

  logic mapped;
  always_comb begin
    case (paddr)
      OFS_CTRL, OFS_STATUS, OFS_PERIOD, OFS_WDOG, OFS_FALLBACK, OFS_FAST, OFS_TASK: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  logic [31:0] rdMux;
  always_comb begin
    rdMux = 32'h0;
    case (paddr)
      OFS_STATUS: begin
        rdMux[ST_RUNNING]  = running_ff;
        rdMux[ST_FAULTY]   = faulty_ff;
        rdMux[ST_WDOG]     = wdFlag_ff;
        rdMux[ST_POVR]     = povrFlag_ff;
        rdMux[ST_PIN]      = pinHigh;
        rdMux[ST_PINFAULT] = pinFault;
      end
      OFS_PERIOD:   rdMux[7:0] = period_ff;
      OFS_WDOG:     rdMux[9:0] = wdLimit_ff;
      OFS_FALLBACK: rdMux[2*GROUPS-1:0] = fallback_ff;
      OFS_FAST:     rdMux[7:0] = fastPeriod_ff;
      OFS_TASK:     rdMux[8:0] = grant;
      default:      rdMux = 32'h0;
    endcase
  end

  // zero wait: ready rises in the setup cycle's following edge
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else if (apbRd) begin
      pready  <= 1'b1;
      pslverr <= ~mapped;
      prdata  <= pwrite ? 32'h0 : rdMux;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      period_ff     <= PERIOD_RST;
      wdLimit_ff    <= WDOG_RST;
      fastPeriod_ff <= FAST_RST;
      fallback_ff   <= '0;
    end else if (apbWr) begin
      case (paddr)
        OFS_PERIOD:   period_ff     <= pwdata[7:0]; // [R13]
        OFS_WDOG:     wdLimit_ff    <= pwdata[9:0];
        OFS_FALLBACK: fallback_ff   <= pwdata[2*GROUPS-1:0];
        OFS_FAST:     fastPeriod_ff <= pwdata[7:0];
        default:      period_ff     <= period_ff;
      endcase
    end
  end

  logic cmdRun, cmdStop, cmdClrFault;
  assign cmdRun      = apbWr & (paddr == OFS_CTRL) & pwdata[CTRL_RUN];
  assign cmdStop     = apbWr & (paddr == OFS_CTRL) & pwdata[CTRL_STOP];
  assign cmdClrFault = apbWr & (paddr == OFS_CTRL) & pwdata[CTRL_CLRFAULT];
  logic stsWr;
  assign stsWr = apbWr & (paddr == OFS_STATUS);

  // restart decision after reset release; straps settle through the synchroniser first
  logic [1:0] startCnt_ff;
  logic       started_ff;
  logic       prevPin_ff;
  logic       prevFault_ff;
  logic       wdTrip;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      startCnt_ff <= 2'h0;
      started_ff  <= 1'b0;
    end else if (!started_ff) begin
      if (startCnt_ff == 2'(START_WAIT - 1)) begin
        started_ff <= 1'b1;
      end
      startCnt_ff <= startCnt_ff + 2'h1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prevPin_ff   <= 1'b0;
      prevFault_ff <= 1'b0;
    end else begin
      prevPin_ff   <= pinHigh;
      prevFault_ff <= pinFault;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      running_ff <= 1'b0;
    end else if (!started_ff) begin
      if (startCnt_ff == 2'(START_WAIT - 1)) begin
        running_ff <= pinHigh & ~pinFault & ~(warmS & keptStopS); // [R06] [R07] [R08]
      end
    end else if (!pinHigh || pinFault || wdTrip || faulty_ff) begin
      running_ff <= 1'b0; // [R01] [R04] [R05] [R17]
    end else if (!prevPin_ff) begin
      running_ff <= 1'b1; // [R02]
    end else if (prevFault_ff) begin
      running_ff <= 1'b1; // [R05]
    end else if (cmdStop) begin
      running_ff <= 1'b0; // [R03]
    end else if (cmdRun) begin
      running_ff <= 1'b1; // [R03]
    end
  end

  // retained for the next warm restart: pin high but stopped
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      keepStopped <= 1'b0;
    end else if (started_ff) begin
      keepStopped <= pinHigh & ~pinFault & ~running_ff; // [R08]
    end
  end

  // scan sequencer
  scanPhase_t phase_ff;
  logic [7:0] perCnt_ff;
  logic       perExp_ff;
  logic [9:0] wdCnt_ff;
  logic       periodic;
  logic       mainGo;
  logic       scanEnd;
  logic       scanStart;
  assign periodic = (period_ff != 8'h00);
  assign mainGo   = grant.mainTask & phaseDone;
  assign scanEnd  = mainGo & ((phase_ff == PH_OUT) | ((phase_ff == PH_IN) & ~running_ff));
  assign scanStart = started_ff & (((phase_ff == PH_IDLE) & (perExp_ff | ~periodic))
                   | (scanEnd & (~periodic | perExp_ff)));

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      phase_ff <= PH_IDLE;
    end else begin
      case (phase_ff)
        PH_IDLE: if (scanStart) phase_ff <= PH_IP; // [R15]
        PH_IP:   if (mainGo) phase_ff <= PH_IN;
        PH_IN: begin
          if (mainGo && running_ff) begin
            phase_ff <= PH_PROG; // [R09]
          end else if (scanEnd) begin
            phase_ff <= scanStart ? PH_IP : PH_IDLE; // [R10]
          end
        end
        PH_PROG: if (mainGo) phase_ff <= PH_OUT;
        PH_OUT: begin
          if (scanEnd) begin
            phase_ff <= scanStart ? PH_IP : PH_IDLE; // [R09] [R16]
          end
        end
        default: phase_ff <= PH_IDLE;
      endcase
    end
  end
  assign phase = phase_ff;

  // period down-counter, in milliseconds
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      perCnt_ff <= 8'h00;
      perExp_ff <= 1'b0;
    end else if (scanStart) begin
      perCnt_ff <= period_ff; // [R14]
      perExp_ff <= 1'b0;
    end else if (perCnt_ff == 8'h00) begin
      perExp_ff <= 1'b1; // [R14] zero left by cyclic mode counts as expired, else a switch stalls
    end else if (msTick_ff && perCnt_ff != 8'h00) begin
      perCnt_ff <= perCnt_ff - 8'h01;
      if (perCnt_ff == 8'h01) begin
        perExp_ff <= 1'b1; // [R14]
      end
    end
  end

  logic povrSet;
  assign povrSet = periodic & msTick_ff & (perCnt_ff == 8'h01) & (phase_ff != PH_IDLE) & ~scanStart;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      povrFlag_ff <= 1'b0;
    end else if (povrSet) begin
      povrFlag_ff <= 1'b1; // [R16]
    end else if (stsWr && pwdata[ST_POVR]) begin
      povrFlag_ff <= 1'b0;
    end
  end

  // watchdog, measured per scan while running
  assign wdTrip = running_ff & (phase_ff != PH_IDLE) & (wdCnt_ff >= wdLimit_ff);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wdCnt_ff <= 10'h000;
    end else if (scanStart) begin
      wdCnt_ff <= 10'h000; // [R23]
    end else if (msTick_ff && phase_ff != PH_IDLE && wdCnt_ff != 10'h3FF) begin
      wdCnt_ff <= wdCnt_ff + 10'h001;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wdFlag_ff <= 1'b0;
      faulty_ff <= 1'b0;
    end else begin
      if (wdTrip) begin
        wdFlag_ff <= 1'b1; // [R17]
      end else if (stsWr && pwdata[ST_WDOG]) begin
        wdFlag_ff <= 1'b0;
      end
      if (wdTrip) begin
        faulty_ff <= 1'b1; // [R17]
      end else if (cmdClrFault) begin
        faulty_ff <= 1'b0;
      end
    end
  end

  // physical outputs: image while running, fallback while stopped
  logic [NO-1:0] lastOut_ff;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lastOut_ff <= '0;
    end else if (running_ff && scanEnd && phase_ff == PH_OUT) begin
      lastOut_ff <= outImage; // [R09]
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      physOut <= '0;
    end else begin
      for (int g = 0; g < GROUPS; g++) begin
        if (running_ff) begin
          physOut[g*8 +: 8] <= lastOut_ff[g*8 +: 8];
        end else begin
          case (fallback_ff[2*g +: 2])
            FB_FORCE0: physOut[g*8 +: 8] <= 8'h00; // [R11]
            FB_FORCE1: physOut[g*8 +: 8] <= 8'hFF; // [R11]
            default:   physOut[g*8 +: 8] <= lastOut_ff[g*8 +: 8]; // [R12]
          endcase
        end
      end
    end
  end

  // fast task period timer, absent when its period is zero
  logic [7:0] fastCnt_ff;
  logic       fastPend_ff;
  logic       fastTick;
  assign fastTick = running_ff & (fastPeriod_ff != 8'h00) & msTick_ff & (fastCnt_ff <= 8'h01);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fastCnt_ff <= 8'h00;
    end else if (!running_ff || fastTick) begin
      fastCnt_ff <= fastPeriod_ff; // [R20]
    end else if (msTick_ff) begin
      fastCnt_ff <= fastCnt_ff - 8'h01;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fastPend_ff <= 1'b0;
    end else if (!running_ff) begin
      fastPend_ff <= 1'b0;
    end else if (fastTick) begin
      fastPend_ff <= 1'b1;
    end else if (taskDone && grant.fastTask) begin
      fastPend_ff <= 1'b0;
    end
  end

  // event tasks; a pending bit stays until its task reports done or the controller stops running
  logic [NEV-1:0] evPend_ff;
  logic [NEV-1:0] evClr;
  always_comb begin
    evClr = '0;
    if (taskDone && grant.eventTask) begin
      evClr[grant.eventNum[$clog2(NEV)-1:0]] = 1'b1;
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      evPend_ff <= '0;
    end else if (!running_ff) begin
      evPend_ff <= '0;
    end else begin
      evPend_ff <= (evPend_ff & ~evClr) | eventReq; // [R22]
    end
  end

  // arbitration: an event in service keeps the grant unless the top event task arrives
  taskGrant_t nxt_grant;
  logic       evBusy;
  logic [5:0] evPick;
  assign evBusy = grant.eventTask & evPend_ff[grant.eventNum[$clog2(NEV)-1:0]];
  always_comb begin
    evPick = 6'h00;
    for (int i = NEV - 1; i >= 0; i--) begin
      if (evPend_ff[i]) begin
        evPick = 6'(i);
      end
    end
    nxt_grant = '0;
    if (evPend_ff[0]) begin
      nxt_grant.eventTask = 1'b1; // [R22] [R21]
    end else if (evBusy) begin
      nxt_grant.eventTask = 1'b1;
      nxt_grant.eventNum  = grant.eventNum;
    end else if (evPend_ff != '0) begin
      nxt_grant.eventTask = 1'b1; // [R20]
      nxt_grant.eventNum  = evPick;
    end else if (fastPend_ff) begin
      nxt_grant.fastTask = 1'b1; // [R20] [R21]
    end else begin
      nxt_grant.mainTask = 1'b1; // [R20]
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      grant <= '{mainTask: 1'b1, fastTask: 1'b0, eventTask: 1'b0, eventNum: 6'h00};
    end else if (taskDone && !grant.mainTask) begin
      grant <= '{mainTask: 1'b1, fastTask: 1'b0, eventTask: 1'b0, eventNum: 6'h00};
    end else begin
      grant <= nxt_grant;
    end
  end

  // lamps: flashing together marks a watchdog fault
  logic [7:0] flashCnt_ff;
  logic       flash_ff;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flashCnt_ff <= 8'h00;
      flash_ff    <= 1'b0;
    end else if (msTick_ff) begin
      if (flashCnt_ff == 8'(FLASH_HALF_MS - 1)) begin
        flashCnt_ff <= 8'h00;
        flash_ff    <= ~flash_ff;
      end else begin
        flashCnt_ff <= flashCnt_ff + 8'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      runLamp <= 1'b0;
      errLamp <= 1'b0;
      running <= 1'b0;
    end else begin
      runLamp <= faulty_ff ? flash_ff : running_ff; // [R17]
      errLamp <= faulty_ff & flash_ff; // [R17]
      running <= running_ff;
    end
  end

endmodule
`default_nettype wire

// ### sim/scan_env_model.sv
/* Program and task side model: ends phases and tasks after lat cycles.
   Assumes the controller's clock, reset and grant. */
`default_nettype none
module scan_env_model
  import scan_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // controller side
  input  wire scanPhase_t phase,
  input  wire taskGrant_t grant,
  input  wire logic [7:0] lat,
  output logic            phaseDone,
  output logic            taskDone,
  output logic [31:0]     outImage
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt;
  taskGrant_t gPrev;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt       <= 8'h00;
      gPrev     <= '0;
      phaseDone <= 1'b0;
      taskDone  <= 1'b0;
      outImage  <= 32'h0;
    end else begin
      gPrev     <= grant;
      phaseDone <= 1'b0;
      taskDone  <= 1'b0;
      // new grant restarts the count, so a resumed task runs its full length
      if (phaseDone || taskDone || grant != gPrev) begin
        cnt <= 8'h00;
      end else if (cnt < lat) begin
        cnt <= cnt + 8'h01;
      end else if (!grant.mainTask) begin
        taskDone <= 1'b1;
      end else if (phase != PH_IDLE) begin
        phaseDone <= 1'b1;
        if (phase == PH_PROG) outImage <= outImage + 32'h01010101;
      end
    end
  end
endmodule
`default_nettype wire

// ### sim/scan_run_ctrl_props.sv
/* Checker for the run/stop and scan controller, bound to its top.
   Assumes the design's port names and package. */
`default_nettype none
module scan_ctrl_props
  import scan_ctrl_pkg::*;
#(
  parameter int GROUPS = 4,
  parameter int NEV    = 32
) (
  // clock and reset
  input wire logic                clk,
  input wire logic                resetn,
  // run state
  input wire logic                psel,
  input wire logic                runPin,
  input wire logic                running,
  input wire logic                errLamp,
  // scan and outputs
  input wire scanPhase_t          phase,
  input wire logic                phaseDone,
  input wire logic [GROUPS*8-1:0] outImage,
  input wire logic [GROUPS*8-1:0] physOut,
  // tasks
  input wire logic [NEV-1:0]      eventReq,
  input wire logic                taskDone,
  input wire taskGrant_t          grant
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  logic adv;
  assign adv = phaseDone && grant.mainTask;
  a_pin_low_stop: assert property ((!runPin) [*5] |-> !running)
    else $error("running while run pin low");
  a_ip_then_input: assert property (phase == PH_IP && adv ##2 running |-> $past(phase) == PH_IN)
    else $error("input read did not follow internal phase");
  a_prog_then_out: assert property (phase == PH_PROG && adv ##2 running |-> $past(phase) == PH_OUT)
    else $error("output update did not follow program");
  a_stop_no_prog: assert property (phase == PH_IN && adv && !running ##1 !running |-> phase != PH_PROG)
    else $error("program ran while stopped");
  a_image_to_out: assert property (phase == PH_OUT && adv ##1 running [*2] |-> physOut == $past(outImage, 2))
    else $error("outputs not taken from image");
  a_stop_out_stable: assert property ((!running && !psel) [*4] |-> $stable(physOut))
    else $error("outputs moved while stopped");
  a_wdog_lamp_stop: assert property ($rose(errLamp) |-> ##[0:2] !running)
    else $error("error lamp while running");
  a_event_zero_first: assert property (eventReq[0] && running && !taskDone ##1 running
    |-> ##[0:3] (grant.eventTask && grant.eventNum == 6'h00))
    else $error("top event task not granted");
  c_run_rise: cover property ($rose(running));
  c_wdog_trip: cover property ($rose(errLamp));
  c_event_zero: cover property (grant.eventTask && grant.eventNum == 6'h00);
endmodule
bind scan_run_ctrl scan_ctrl_props #(.GROUPS(GROUPS), .NEV(NEV)) u_props (
  .clk, .resetn, .psel, .runPin, .running, .errLamp, .phase, .phaseDone,
  .outImage, .physOut, .eventReq, .taskDone, .grant
);
`default_nettype wire

// ### sim/tb_top.sv
/* Self-checking bench for the run/stop and scan controller.
   Assumes the env model answers phases and tasks. */
`default_nettype none
module tb_top
  import scan_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int          MS    = 10;
  localparam logic [31:0] bRun  = 32'h1 << ST_RUNNING;
  localparam logic [31:0] bFlt  = 32'h1 << ST_FAULTY;
  localparam logic [31:0] bWd   = 32'h1 << ST_WDOG;
  localparam logic [31:0] bPo   = 32'h1 << ST_POVR;
  localparam logic [31:0] bPin  = 32'h1 << ST_PIN;
  localparam logic [31:0] bPf   = 32'h1 << ST_PINFAULT;
  localparam logic [31:0] cRun  = 32'h1 << CTRL_RUN;
  localparam logic [31:0] cStop = 32'h1 << CTRL_STOP;
  localparam logic [31:0] cClr  = 32'h1 << CTRL_CLRFAULT;
  logic        clk, resetn, psel, penable, pwrite, pready, pslverr, lastErr;
  logic        runPin, runPinFault, warmStart, keptStopped, keepStopped;
  logic        phaseDone, taskDone, running, runLamp, errLamp;
  logic [7:0]  paddr, lat;
  logic [31:0] pwdata, prdata, outImage, physOut, eventReq, lastRun, q;
  scanPhase_t  phase, prevPh;
  taskGrant_t  grant;
  int          n_fail, compares, cycles, sinceIp, lastGap;

  scan_run_ctrl #(.MS_CNT(MS)) u_dut (
    .clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .runPin, .runPinFault, .warmStart, .keptStopped, .keepStopped, .phase, .phaseDone,
    .outImage, .physOut, .eventReq, .taskDone, .grant, .running, .runLamp, .errLamp
  );
  scan_env_model u_env (.clk, .resetn, .phase, .grant, .lat, .phaseDone, .taskDone, .outImage);

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    prevPh <= phase;
    sinceIp <= (phase == PH_IP && prevPh != PH_IP) ? 1 : sinceIp + 1;
    if (phase == PH_IP && prevPh != PH_IP) lastGap <= sinceIp;
    if (running) lastRun <= physOut;
  end

  task automatic results();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // whole run needs a few thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      n_fail++;
      results();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      n_fail++;
      $display("mismatch at %0t: saw %h expected %h", $time, s, e);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (!pready) begin
      @(posedge clk);
    end
    q = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(q & m, e);
  endtask

  task automatic st(input logic [31:0] e);
    cyc(8);
    rd(OFS_STATUS, 32'h3F, e);
  endtask

  task automatic rng(input int lo, input int hi);
    chk({31'h0, lastGap >= lo && lastGap <= hi}, 32'h1);
  endtask

  task automatic wgr(input taskGrant_t g);
    int n;
    n = 0;
    while (grant !== g && n < 40) begin
      n++;
      @(posedge clk);
    end
    chk({23'h0, grant}, {23'h0, g});
  endtask

  task automatic boot(input logic w, input logic k, input logic p, input logic f);
    resetn <= 1'b0;
    warmStart <= w;
    keptStopped <= k;
    runPin <= p;
    runPinFault <= f;
    cyc(16);
    resetn <= 1'b1;
    cyc(10);
  endtask

  initial begin
    {psel, penable, pwrite, paddr, pwdata, eventReq} <= '0;
    {resetn, runPin, runPinFault, warmStart, keptStopped, lat} <= '0;
    boot(1'b0, 1'b0, 1'b1, 1'b0);
    rd(OFS_PERIOD, 32'hFF, {24'h0, PERIOD_RST});
    rd(OFS_WDOG, 32'h3FF, {22'h0, WDOG_RST});
    rd(8'h40, 32'hFFFFFFFF, 32'h0);
    chk({31'h0, lastErr}, 32'h1);
    st(bRun | bPin);
    wr(OFS_CTRL, cStop);
    st(bPin);
    chk({31'h0, keepStopped}, 32'h1);
    wr(OFS_CTRL, cRun);
    st(bRun | bPin);
    runPin <= 1'b0;
    st(32'h0);
    wr(OFS_CTRL, cRun);
    st(32'h0);
    runPin <= 1'b1;
    st(bRun | bPin);
    runPinFault <= 1'b1;
    st(bPin | bPf);
    runPinFault <= 1'b0;
    st(bRun | bPin);
    wr(OFS_FALLBACK, {24'h0, FB_HOLD, FB_HOLD, FB_FORCE0, FB_FORCE1});
    wr(OFS_CTRL, cStop);
    cyc(8);
    chk(physOut, {lastRun[31:16], 8'h00, 8'hFF});
    wr(OFS_FALLBACK, 32'hFF);
    cyc(4);
    chk(physOut, 32'hFFFFFFFF);
    wr(OFS_CTRL, cRun);
    for (int p = 2; p <= 5; p += 3) begin
      // watchdog stays at its 250 ms reset value, far above the period
      wr(OFS_PERIOD, 32'(p));
      cyc(200);
      rng((p - 1) * MS, p * MS + 3);
    end
    wr(OFS_STATUS, bPo);
    st(bRun | bPin);
    wr(OFS_PERIOD, 32'h2);
    lat <= 8'h08;
    cyc(200);
    st(bRun | bPin | bPo);
    rng(40, 45);
    lat <= 8'h00;
    cyc(60);
    wr(OFS_STATUS, bPo);
    st(bRun | bPin);
    wr(OFS_PERIOD, 32'h0);
    wr(OFS_WDOG, 32'h2);
    cyc(300);
    st(bRun | bPin);
    rng(8, 9);
    lat <= 8'h08;
    cyc(100);
    st(bFlt | bWd | bPin);
    wr(OFS_CTRL, cRun);
    st(bFlt | bWd | bPin);
    // lamps flash with a 250 ms half period, so wait for the lit half
    for (int i = 0; i < 5100 && !errLamp; i++) cyc(1);
    chk({29'h0, running, runLamp, errLamp}, 32'h3);
    lat <= 8'h00;
    wr(OFS_CTRL, cClr);
    wr(OFS_STATUS, bWd);
    wr(OFS_CTRL, cRun);
    st(bRun | bPin);
    chk({29'h0, running, runLamp, errLamp}, 32'h6);
    wr(OFS_WDOG, 32'h3FF);
    lat <= 8'h08;
    eventReq <= 32'h20;
    cyc(1);
    eventReq <= 32'h0;
    wgr(taskGrant_t'(9'h045));
    eventReq <= 32'h1;
    cyc(1);
    eventReq <= 32'h0;
    wgr(taskGrant_t'(9'h040));
    wgr(taskGrant_t'(9'h045));
    wgr(taskGrant_t'(9'h100));
    rd(OFS_TASK, 32'h1FF, 32'h100);
    lat <= 8'h00;
    boot(1'b1, 1'b1, 1'b1, 1'b0);
    st(bPin);
    boot(1'b1, 1'b0, 1'b1, 1'b0);
    st(bRun | bPin);
    boot(1'b1, 1'b0, 1'b1, 1'b1);
    st(bPin | bPf);
    boot(1'b1, 1'b0, 1'b0, 1'b0);
    st(32'h0);
    results();
  end
endmodule
`default_nettype wire
